// ===== inc/audio_pwm_pkg.sv
// Constants, register map and carrier types of the signed audio output stage.
package audio_pwm_pkg;

	// Register port geometry.
	localparam int ADDR_WIDTH = 5;
	localparam int DATA_WIDTH = 4;

	// Register offsets on the register port.
	localparam logic [4:0] STATUS_OFFSET = 5'h00;
	localparam logic [4:0] EXTRA_LOW_OFFSET = 5'h08;
	localparam logic [4:0] CONTROL_OFFSET = 5'h09;
	localparam logic [4:0] LOW_NIBBLE_OFFSET = 5'h0a;
	localparam logic [4:0] HIGH_NIBBLE_OFFSET = 5'h0b;
	localparam logic [4:0] IRQ_MASK_OFFSET = 5'h10;

	// Field positions.
	localparam int FLAG_BIT = 2;
	localparam int OUTPUT_ENABLE_BIT = 0;
	localparam int GLOBAL_IRQ_ENABLE_BIT = 1;
	localparam int SIGN_BIT = 3;

	// Values after reset.
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h4;

	// Conversion timing, in hertz, and the derived cycle counts.
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int IRQ_RATE_HZ = 32768;
	localparam int DOUBLE_IRQ_RATE_HZ = 65536;
	localparam int PERIOD_CYCLES = SYS_CLK_HZ / IRQ_RATE_HZ;
	localparam int DOUBLE_PERIOD_CYCLES = SYS_CLK_HZ / DOUBLE_IRQ_RATE_HZ;
	localparam int COUNT_WIDTH = 12;

	// Resolutions the converter can be built for.
	localparam int RES_8 = 8;
	localparam int RES_10 = 10;
	localparam int RES_12 = 12;

	// A sign-magnitude sample at the widest resolution.
	typedef struct packed {
		logic sign;
		logic [10:0] magnitude;
	} sample_type;

	// Level and drive enable of both differential speaker pins.
	typedef struct packed {
		logic positive;
		logic negative;
		logic positive_oe;
		logic negative_oe;
	} speaker_pins_type;

	// One register port access.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [3:0] wdata;
	} reg_access_type;

endpackage

// ===== verilog/conversion_timer.sv
// Conversion cycle timer: counts system clocks within one output cycle.
`timescale 1ns/1ns
module conversion_timer
	import audio_pwm_pkg::*;
#(
	parameter int PERIOD = PERIOD_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_run,
	output logic [COUNT_WIDTH-1:0] o_count,
	output logic o_cycle_end
);

	if (PERIOD < 2 || PERIOD > (1 << COUNT_WIDTH)) begin : g_bad_period
		$error("conversion_timer: period does not fit the counter");
	end

	localparam logic [COUNT_WIDTH-1:0] LAST = COUNT_WIDTH'(PERIOD - 1);

	typedef struct packed {
		logic [COUNT_WIDTH-1:0] count;
	} timer_state_type;

	timer_state_type state_reg;
	timer_state_type state_next;

	// The counter parks at zero while stopped, so a restart begins a full cycle.
	always_comb begin
		state_next = state_reg;
		if (!i_run) begin
			state_next.count = '0;
		end else if (state_reg.count == LAST) begin
			state_next.count = '0;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_reg <= '0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	assign o_count = state_reg.count;
	assign o_cycle_end = i_run && (state_reg.count == LAST);

endmodule

// ===== verilog/signed_audio_pwm_dac_output.sv
// Signed audio output stage: sample registers, pulse output, DAC and interrupt.
// What this block does
// - Resolution is 8, 10 or 12 bits, fixed by build option.
// - Top bit of the high nibble is the sign, 0 positive, 1 negative.
// - A build option sends the samples to the DAC instead of the pins.
// - Every completed conversion cycle raises an interrupt request.
// - Each interrupt request sets the conversion interrupt flag to 1.
// - Conversion cycles, and so interrupts, run at 32768 Hz, or 65536 Hz by build option.
// - 8-bit sample is high and low nibble; seven bits give pulse clocks.
// - Written samples wait in a holding buffer, loaded at output start and at each cycle end.
// - Output enable starts output; while disabled both pins are low.
// - Halt clears output enable and releases both pins.
// - 10-bit sample adds extra-low bits 3:2, magnitude 0 to 511.
// - 12-bit sample adds all four extra-low bits, magnitude 0 to 2047.
// - Ten-bit option uses two extra bits; twelve-bit option uses four.
// - Control bit 1 is global interrupt enable, bit 0 output enable.
// - Hardware never clears the interrupt flag; software clears it.
// - Interrupt rate is 32768 Hz, or 65536 Hz by build option.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module signed_audio_pwm_dac_output
	import audio_pwm_pkg::*;
#(
	parameter bit TEN_BIT_OPTION = 1'b0,
	parameter bit TWELVE_BIT_OPTION = 1'b0,
	parameter bit DAC_SELECT_OPTION = 1'b0,
	parameter bit DOUBLE_IRQ_RATE_OPTION = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_halt,
	input wire logic [ADDR_WIDTH-1:0] i_addr,
	input wire logic [DATA_WIDTH-1:0] i_wr_data,
	input wire logic i_wr_strobe,
	input wire logic i_rd_strobe,
	output logic [DATA_WIDTH-1:0] o_rd_data,
	output logic o_irq,
	output logic o_speaker_out_positive,
	output logic o_speaker_out_positive_oe,
	output logic o_speaker_out_negative,
	output logic o_speaker_out_negative_oe,
	output logic [11:0] o_dac_sample
);

	localparam int RESOLUTION = TWELVE_BIT_OPTION ? RES_12 :
		(TEN_BIT_OPTION ? RES_10 : RES_8);
	localparam int PERIOD = DOUBLE_IRQ_RATE_OPTION ? DOUBLE_PERIOD_CYCLES :
		PERIOD_CYCLES;

	if (PERIOD >= (1 << COUNT_WIDTH)) begin : g_bad_rate
		$error("signed_audio_pwm_dac_output: period too long for counter");
	end

	typedef struct packed {
		logic [3:0] high_nibble;
		logic [3:0] low_nibble;
		logic [3:0] extra_low;
		logic output_enable;
		logic global_irq_enable;
		logic halted;
		logic running;
		logic irq_flag;
		logic [3:0] irq_mask;
		sample_type active;
		speaker_pins_type pins;
		logic [11:0] dac;
		logic [3:0] rd_data;
		logic irq;
	} block_state_type;

	block_state_type state_reg;
	block_state_type state_next;
	reg_access_type access;
	sample_type composed;
	sample_type current;
	logic run;
	logic load;
	logic cycle_end;
	logic [COUNT_WIDTH-1:0] count;

	// sign from the top of the high nibble
	// Packs the three holding nibbles into one sign-magnitude sample.
	function automatic sample_type compose_sample(input logic [3:0] hi,
			input logic [3:0] lo, input logic [3:0] xlo);
		sample_type s;
		s.sign = hi[SIGN_BIT];
		case (RESOLUTION)
			RES_8: begin
				s.magnitude = {4'h0, hi[2:0], lo};
			end
			RES_10: begin
				s.magnitude = {2'h0, hi[2:0], lo, xlo[3:2]};
			end
			RES_12: begin
				s.magnitude = {hi[2:0], lo, xlo};
			end
			default: begin
				s.magnitude = '0;
			end
		endcase
		return s;
	endfunction

	// Bus signals gathered into one access record.
	assign access = '{wr: i_wr_strobe, rd: i_rd_strobe, addr: i_addr,
		wdata: i_wr_data};

	// output runs only while enabled and not halted
	assign run = state_reg.output_enable && !state_reg.halted;
	assign composed = compose_sample(state_reg.high_nibble,
		state_reg.low_nibble, state_reg.extra_low);
	// load on start and at each cycle end only
	assign load = run && (!state_reg.running || cycle_end);
	// The loading cycle already shows the new sample, so no clock is lost.
	assign current = load ? composed : state_reg.active;

	conversion_timer #(
		.PERIOD(PERIOD)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_clk_en(i_clk_en),
		.i_run(run),
		.o_count(count),
		.o_cycle_end(cycle_end)
	);

	// Next-state logic for registers, buffer, pins and interrupt.
	always_comb begin
		state_next = state_reg;
		state_next.running = run;
		state_next.rd_data = '0;

		// Register writes; holding nibbles read back as zero.
		if (access.wr) begin
			case (access.addr)
				EXTRA_LOW_OFFSET: begin
					state_next.extra_low = access.wdata;
				end
				LOW_NIBBLE_OFFSET: begin
					state_next.low_nibble = access.wdata;
				end
				HIGH_NIBBLE_OFFSET: begin
					state_next.high_nibble = access.wdata;
				end
				CONTROL_OFFSET: begin
					state_next.output_enable = access.wdata[OUTPUT_ENABLE_BIT];
					state_next.global_irq_enable =
						access.wdata[GLOBAL_IRQ_ENABLE_BIT];
					state_next.halted = 1'b0;
				end
				STATUS_OFFSET: begin
					if (access.wdata[FLAG_BIT]) begin
						state_next.irq_flag = 1'b0;
					end
				end
				IRQ_MASK_OFFSET: begin
					state_next.irq_mask = access.wdata;
				end
				default: begin
				end
			endcase
		end

		// Reads answer in the next cycle; unmapped addresses give zero.
		if (access.rd) begin
			case (access.addr)
				STATUS_OFFSET: begin
					state_next.rd_data[FLAG_BIT] = state_reg.irq_flag;
				end
				CONTROL_OFFSET: begin
					state_next.rd_data[OUTPUT_ENABLE_BIT] =
						state_reg.output_enable;
					state_next.rd_data[GLOBAL_IRQ_ENABLE_BIT] =
						state_reg.global_irq_enable;
				end
				IRQ_MASK_OFFSET: begin
					state_next.rd_data = state_reg.irq_mask;
				end
				default: begin
				end
			endcase
		end

		// halt wins over a same-cycle control write
		if (i_halt) begin
			state_next.output_enable = 1'b0;
			state_next.halted = 1'b1;
		end

		// holding buffer copied into the active sample
		if (load) begin
			state_next.active = composed;
		end

		// the flag is set, and the set beats a clear
		if (cycle_end) begin
			state_next.irq_flag = 1'b1;
		end

		// DAC takes the sample instead of the pulse stage
		if (DAC_SELECT_OPTION && load) begin
			state_next.dac = {current.sign, current.magnitude};
		end

		// pulse on the pin that matches the sign
		// The magnitude is widened, since a cut count would relight the pin.
		state_next.pins.positive = run && !DAC_SELECT_OPTION &&
			!current.sign && (count < COUNT_WIDTH'(current.magnitude));
		state_next.pins.negative = run && !DAC_SELECT_OPTION &&
			current.sign && (count < COUNT_WIDTH'(current.magnitude));
		state_next.pins.positive_oe = !state_reg.halted;
		state_next.pins.negative_oe = !state_reg.halted;
		if (state_reg.halted) begin
			state_next.pins.positive = 1'b0;
			state_next.pins.negative = 1'b0;
		end

		// Level interrupt from the flag, its mask and the global enable.
		state_next.irq = state_next.irq_flag &&
			state_next.irq_mask[FLAG_BIT] && state_next.global_irq_enable;
	end

	// State register; everything freezes while the clock enable is low.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_reg <= '0;
			state_reg.irq_mask <= IRQ_MASK_RESET;
			state_reg.high_nibble <= NIBBLE_RESET;
			state_reg.pins.positive_oe <= 1'b1;
			state_reg.pins.negative_oe <= 1'b1;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	// Every output comes straight from the state register.
	assign o_rd_data = state_reg.rd_data;
	assign o_irq = state_reg.irq;
	assign o_speaker_out_positive = state_reg.pins.positive;
	assign o_speaker_out_positive_oe = state_reg.pins.positive_oe;
	assign o_speaker_out_negative = state_reg.pins.negative;
	assign o_speaker_out_negative_oe = state_reg.pins.negative_oe;
	assign o_dac_sample = state_reg.dac;

	// Helper: clocks since the last cycle end, for the period check.
	logic [COUNT_WIDTH:0] gap_count;
	logic gap_valid;
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !run) begin
			gap_count <= '0;
			gap_valid <= 1'b0;
		end else if (i_clk_en) begin
			if (cycle_end) begin
				gap_count <= '0;
				gap_valid <= 1'b1;
			end else begin
				gap_count <= gap_count + 1'b1;
			end
		end
	end

	sequence s_cycle_end;
		i_clk_en && cycle_end;
	endsequence

	sequence s_halt_taken;
		!state_reg.output_enable && state_reg.halted;
	endsequence

	property p_flag_set;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		s_cycle_end |=> state_reg.irq_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag not set after a conversion cycle");

	property p_flag_sticky;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		state_reg.irq_flag && !(access.wr && access.addr == STATUS_OFFSET &&
			access.wdata[FLAG_BIT]) |=> state_reg.irq_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag cleared without a software clear");

	property p_irq_raise;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		s_cycle_end ##0 (state_reg.irq_mask[FLAG_BIT] &&
			state_reg.global_irq_enable && !access.wr && !i_halt) |=> o_irq;
	endproperty
	a_irq_raise: assert property (p_irq_raise)
		else $error("interrupt not raised at cycle end");

	property p_period;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		s_cycle_end ##0 gap_valid |-> gap_count == (COUNT_WIDTH + 1)'(PERIOD - 1);
	endproperty
	a_period: assert property (p_period)
		else $error("conversion cycle length is wrong");

	property p_load_at_end;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		s_cycle_end |=> state_reg.active.sign == $past(state_reg.high_nibble[3]);
	endproperty
	a_load_at_end: assert property (p_load_at_end)
		else $error("sign not taken from high nibble at cycle end");

	property p_hold_mid_cycle;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		run && state_reg.running && !cycle_end |=> $stable(state_reg.active);
	endproperty
	a_hold_mid_cycle: assert property (p_hold_mid_cycle)
		else $error("active sample changed inside a cycle");

	property p_disabled_low;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		!state_reg.output_enable |=> !o_speaker_out_positive &&
			!o_speaker_out_negative;
	endproperty
	a_disabled_low: assert property (p_disabled_low)
		else $error("speaker pins driven while output disabled");

	property p_halt;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		i_halt |=> s_halt_taken ##1 (!o_speaker_out_positive_oe &&
			!o_speaker_out_negative_oe);
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not disable and release the pins");

	property p_pulse_sign;
		@(posedge i_sys_clk) disable iff (i_reset || !i_clk_en)
		run && !DAC_SELECT_OPTION && count == '0 && current.magnitude != '0
			|=> (o_speaker_out_positive == !$past(current.sign)) &&
			(o_speaker_out_negative == $past(current.sign));
	endproperty
	a_pulse_sign: assert property (p_pulse_sign)
		else $error("pulse on the wrong speaker pin");

endmodule

// ===== dv/speaker_model.sv
// Speaker model: counts driven-high clocks on each differential pin.
`timescale 1ns/1ns
module speaker_model (
	input wire logic i_sys_clk,
	input wire logic i_clear,
	input wire logic i_pos,
	input wire logic i_pos_oe,
	input wire logic i_neg,
	input wire logic i_neg_oe,
	output logic [11:0] o_pos_count,
	output logic [11:0] o_neg_count,
	output logic o_overlap
);
	logic pos_on;
	logic neg_on;

	// A released pin moves no cone, so only driven-high clocks count.
	assign pos_on = i_pos & i_pos_oe;
	assign neg_on = i_neg & i_neg_oe;

	// The clear edge keeps its own sample so no pulse clock is lost.
	always_ff @(posedge i_sys_clk) begin
		o_pos_count <= (i_clear ? 12'h000 : o_pos_count) + {11'h000, pos_on};
		o_neg_count <= (i_clear ? 12'h000 : o_neg_count) + {11'h000, neg_on};
		o_overlap <= (i_clear ? 1'b0 : o_overlap) | (pos_on & neg_on);
	end
endmodule

// ===== dv/tb.sv
// Self-checking bench of the signed audio output stage.
`timescale 1ns/1ns
module tb;
	import audio_pwm_pkg::*;
	logic clk, rst, clk_en, halt, wr, rd, clr, irq, pp, ppoe, pn, pnoe;
	logic p2, n2, ovl;
	logic [4:0] addr;
	logic [3:0] wdata, rd_data, hi, lo, xlo;
	logic [11:0] dac, dac2, pc, nc, prev;
	int n_mismatch, cmp_count, cyc, last;

	signed_audio_pwm_dac_output dut (.i_sys_clk(clk), .i_reset(rst),
		.i_clk_en(clk_en), .i_halt(halt), .i_addr(addr), .i_wr_data(wdata),
		.i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(rd_data), .o_irq(irq),
		.o_speaker_out_positive(pp), .o_speaker_out_positive_oe(ppoe),
		.o_speaker_out_negative(pn), .o_speaker_out_negative_oe(pnoe),
		.o_dac_sample(dac));

	// Twelve-bit DAC build shares the register traffic of the first one.
	signed_audio_pwm_dac_output #(.TWELVE_BIT_OPTION(1'b1),
		.DAC_SELECT_OPTION(1'b1)) dut_dac (.i_sys_clk(clk), .i_reset(rst),
		.i_clk_en(clk_en), .i_halt(halt), .i_addr(addr), .i_wr_data(wdata),
		.i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(), .o_irq(),
		.o_speaker_out_positive(p2), .o_speaker_out_positive_oe(),
		.o_speaker_out_negative(n2), .o_speaker_out_negative_oe(),
		.o_dac_sample(dac2));

	speaker_model spk (.i_sys_clk(clk), .i_clear(clr), .i_pos(pp),
		.i_pos_oe(ppoe), .i_neg(pn), .i_neg_oe(pnoe), .o_pos_count(pc),
		.o_neg_count(nc), .o_overlap(ovl));

	// Clock and a cycle count that moves off the sampling edge.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) cyc++;

	// Expected pulse clocks on the pin of sign s for an 8-bit sample.
	function automatic logic [11:0] pin_cnt(input logic [3:0] h,
		input logic [3:0] l, input logic s);
		return (h[3] == s) ? {5'h00, h[2:0], l} : 12'h000;
	endfunction

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd_reg(input logic [4:0] a, input logic [3:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk({8'h00, rd_data}, {8'h00, e});
	endtask

	// Bounded wait; running out of time counts as a mismatch.
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (irq !== 1'b1 && n < 3200);
		if (irq !== 1'b1) begin
			n_mismatch++;
			$display("Error %0t: no interrupt in time", $time);
		end
	endtask

	task automatic load_sample();
		wr_reg(EXTRA_LOW_OFFSET, xlo);
		wr_reg(LOW_NIBBLE_OFFSET, lo);
		wr_reg(HIGH_NIBBLE_OFFSET, hi);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Eight conversion cycles of about 3051 clocks fit well inside this.
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		halt = 1'b0;
		addr = 5'h00;
		wdata = 4'h0;
		wr = 1'b0;
		rd = 1'b0;
		clr = 1'b1;
		void'($urandom(52767));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		clr <= 1'b0;
		// Reset state, write-only and unmapped places.
		rd_reg(STATUS_OFFSET, 4'h0); // flag clear
		rd_reg(CONTROL_OFFSET, 4'h0); // both enables off
		rd_reg(IRQ_MASK_OFFSET, IRQ_MASK_RESET); // mask value
		rd_reg(HIGH_NIBBLE_OFFSET, 4'h0); // buffer unreadable
		rd_reg(5'h1f, 4'h0); // unmapped place
		chk({8'h00, pp, pn, ppoe, pnoe}, 12'h003); // driven low
		// A write while the clock enable is low must leave no trace.
		clk_en <= 1'b0;
		wr_reg(CONTROL_OFFSET, 4'h3); // frozen write
		clk_en <= 1'b1;
		rd_reg(CONTROL_OFFSET, 4'h0); // frozen write lost
		// Full negative sample written before the output starts.
		hi = 4'hf;
		lo = 4'hf;
		xlo = 4'h5;
		// The sample in use; the pins of a cycle show the one loaded before.
		prev = {hi, lo, xlo};
		load_sample(); // sample first
		wr_reg(CONTROL_OFFSET, 4'h3); // enables on
		for (int k = 0; k < 8; k++) begin
			wait_irq(); // cycle interrupt
			if (k > 0 && k != 4) chk(12'(cyc - last), 12'(PERIOD_CYCLES));
			last = cyc;
			clr <= 1'b1;
			chk(pc, pin_cnt(prev[11:8], prev[7:4], 1'b0)); // positive pulse
			chk(nc, pin_cnt(prev[11:8], prev[7:4], 1'b1)); // sign pin
			chk({11'h000, ovl}, 12'h000); // other pin low
			chk(dac2, {hi, lo, xlo}); // twelve-bit word
			chk(dac, 12'h000); // no DAC word
			chk({10'h000, p2, n2}, 12'h000); // DAC pins quiet
			prev = {hi, lo, xlo};
			@(posedge clk);
			clr <= 1'b0;
			rd_reg(STATUS_OFFSET, 4'h4); // flag set
			if (k == 3) begin
				// Mask, then global enable, must hold the line low.
				wr_reg(IRQ_MASK_OFFSET, 4'h0);
				repeat (2) @(posedge clk);
				chk({11'h000, irq}, 12'h000); // masked
				wr_reg(CONTROL_OFFSET, 4'h1);
				wr_reg(IRQ_MASK_OFFSET, 4'h4);
				repeat (2) @(posedge clk);
				chk({11'h000, irq}, 12'h000); // global off
				wr_reg(CONTROL_OFFSET, 4'h3);
				repeat (2) @(posedge clk);
				chk({11'h000, irq}, 12'h001); // flag kept
			end
			// Corner samples among random ones; one cycle reuses the last.
			case (k)
				0: {hi, lo, xlo} = 12'h000;
				1: {hi, lo, xlo} = 12'h80f;
				5: {hi, lo, xlo} = 12'h7f0;
				default: {hi, lo, xlo} = 12'($urandom);
			endcase
			if (k != 4) load_sample(); // write early
			if (k == 4) {hi, lo, xlo} = prev; // reuse old
			wr_reg(STATUS_OFFSET, 4'h4); // software clear
			repeat (2) @(posedge clk);
			chk({11'h000, irq}, 12'h000); // cleared
		end
		// Disable drives both pins low.
		wr_reg(CONTROL_OFFSET, 4'h0);
		repeat (3) @(posedge clk);
		chk({8'h00, pp, pn, ppoe, pnoe}, 12'h003); // stopped
		// Halt releases both pins and drops the output enable.
		wr_reg(CONTROL_OFFSET, 4'h1);
		@(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		repeat (2) @(posedge clk);
		chk({8'h00, pp, pn, ppoe, pnoe}, 12'h000); // pins released
		rd_reg(CONTROL_OFFSET, 4'h0); // enable cleared
		finish_test();
	end
endmodule
